// *** rtl/input_capture_channel.sv ***
// Input capture channel with APB register access.
// Assumes synchronous pin and timer counts in the pclk domain.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module input_capture_channel #(
    parameter int  count_width = 16,
    parameter bit  has_dma     = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_pin,
    input  wire logic [15:0] first_time_base_count,
    input  wire logic [15:0] second_time_base_count,
    input  wire logic        cpu_idle,
    input  wire logic        cpu_sleep,
    output logic             capture_irq,
    output logic             wake_request,
    output logic             dma_request
);
    initial begin
        if (count_width != 16) begin
            $error("input_capture_channel supports 16-bit time bases only");
        end
    end

    logic        stop_in_idle;
    logic        time_base_select;
    logic [1:0]  captures_per_interrupt;
    logic [2:0]  capture_mode_select;
    logic        capture_overflow_flag;
    logic        buffer_not_empty_flag;
    logic        pin_last;
    logic [4:0]  prescale_count;
    logic [1:0]  irq_count;
    logic        fifo_full;
    logic        fifo_empty;
    logic [15:0] fifo_head;
    logic        next_event;
    logic        next_prescaled;
    logic        halted;
    logic        rising;
    logic        falling;
    logic        push;
    logic        pop;
    logic        wr_ctrl;
    logic        rd_buf;
    logic        pop_armed;
    logic [15:0] sampled;
    logic [15:0] control_view;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    assign rising  = capture_input_pin & ~pin_last;
    assign falling = ~capture_input_pin & pin_last;
    assign halted  = stop_in_idle & cpu_idle;
    assign wr_ctrl = psel & penable & pwrite & addr_is(paddr, capture_pkg::control_offset);
    assign rd_buf  = psel & penable & ~pwrite & addr_is(paddr, capture_pkg::buffer_offset);
    assign pop     = rd_buf & pop_armed;
    assign sampled = time_base_select ? first_time_base_count : second_time_base_count;

    always_comb begin
        next_event     = 1'b0;
        next_prescaled = 1'b0;
        case (capture_pkg::mode_type'(capture_mode_select))
            capture_pkg::mode_every:  next_event = rising | falling;
            capture_pkg::mode_fall:   next_event = falling;
            capture_pkg::mode_rise:   next_event = rising;
            capture_pkg::mode_rise4: begin
                next_prescaled = rising;
                next_event = rising && (prescale_count + 5'h01 == capture_pkg::prescale_four);
            end
            capture_pkg::mode_rise16: begin
                next_prescaled = rising;
                next_event = rising && (prescale_count + 5'h01 == capture_pkg::prescale_sixteen);
            end
            default:                  next_event = 1'b0;
        endcase
        if (halted) begin
            next_event     = 1'b0;
            next_prescaled = 1'b0;
        end
    end

    assign push = next_event & ~fifo_full;

    // Pop only what the setup cycle showed; a capture landing
    // between setup and access stays queued instead of being lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_armed <= 1'b0;
        end else begin
            pop_armed <= psel & ~penable & ~pwrite & ~fifo_empty &
                         addr_is(paddr, capture_pkg::buffer_offset);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_last <= 1'b0;
        end else begin
            pin_last <= capture_input_pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= 5'h00;
        end else if (wr_ctrl || !next_prescaled && capture_mode_select == 3'h0) begin
            prescale_count <= 5'h00;
        end else if (next_event) begin
            prescale_count <= 5'h00;
        end else if (next_prescaled) begin
            prescale_count <= prescale_count + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_in_idle           <= capture_pkg::control_reset[capture_pkg::stop_idle_bit];
            time_base_select       <= capture_pkg::control_reset[capture_pkg::time_sel_bit];
            captures_per_interrupt <= 2'h0;
            capture_mode_select    <= 3'h0;
        end else if (wr_ctrl) begin
            stop_in_idle           <= pwdata[capture_pkg::stop_idle_bit];
            time_base_select       <= pwdata[capture_pkg::time_sel_bit];
            captures_per_interrupt <= pwdata[capture_pkg::per_int_lsb +: 2];
            capture_mode_select    <= pwdata[capture_pkg::mode_lsb +: 3];
        end
    end

    // Overflow and buffer cleared only when the channel is turned off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_overflow_flag <= 1'b0;
        end else if (next_event && fifo_full) begin
            capture_overflow_flag <= 1'b1;
        end else if (capture_mode_select == 3'h0) begin
            capture_overflow_flag <= 1'b0;
        end
    end

    capture_fifo #(
        .width (16),
        .depth (capture_pkg::fifo_depth)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (capture_mode_select == 3'h0),
        .push      (push),
        .push_data (sampled),
        .pop       (pop),
        .head      (fifo_head),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_not_empty_flag <= 1'b0;
        end else begin
            buffer_not_empty_flag <= ~fifo_empty;
        end
    end

    // Interrupt pulse after N captures; every-edge mode pulses each capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_count   <= 2'h0;
            capture_irq <= 1'b0;
        end else begin
            capture_irq <= 1'b0;
            if (wr_ctrl) begin
                irq_count <= 2'h0;
            end else if (capture_mode_select == 3'h7) begin
                capture_irq <= rising & (cpu_sleep | cpu_idle);
            end else if (next_event) begin
                if (capture_mode_select == 3'h1 || irq_count == captures_per_interrupt) begin
                    capture_irq <= 1'b1;
                    irq_count   <= 2'h0;
                end else begin
                    irq_count <= irq_count + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_request <= 1'b0;
            dma_request  <= 1'b0;
        end else begin
            wake_request <= (cpu_sleep | cpu_idle) & (capture_mode_select == 3'h7 ? rising
                                                                                 : next_event);
            dma_request  <= has_dma & push & (captures_per_interrupt == 2'h0);
        end
    end

    always_comb begin
        control_view = 16'h0000;
        control_view[capture_pkg::stop_idle_bit]      = stop_in_idle;
        control_view[capture_pkg::time_sel_bit]       = time_base_select;
        control_view[capture_pkg::per_int_lsb +: 2]   = captures_per_interrupt;
        control_view[capture_pkg::overflow_bit]       = capture_overflow_flag;
        control_view[capture_pkg::not_empty_bit]      = buffer_not_empty_flag;
        control_view[capture_pkg::mode_lsb +: 3]      = capture_mode_select;
    end

    // Zero-wait slave; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                if (addr_is(paddr, capture_pkg::control_offset)) begin
                    prdata <= {16'h0000, control_view};
                end else if (addr_is(paddr, capture_pkg::buffer_offset)) begin
                    prdata <= {16'h0000, fifo_empty ? 16'h0000 : fifo_head};
                end else begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            end
        end
    end

    property p_full_drop;
        @(posedge pclk) disable iff (!presetn)
        (next_event && fifo_full) |=> capture_overflow_flag;
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("overflow not set");

    property p_no_push_full;
        @(posedge pclk) disable iff (!presetn)
        (fifo_full && !pop && capture_mode_select != 3'h0) |=>
            (fifo_full && $stable(fifo_head));
    endproperty
    a_no_push_full: assert property (p_no_push_full) else $error("push when full");

    property p_off_idle;
        @(posedge pclk) disable iff (!presetn)
        (capture_mode_select == 3'h0 || capture_mode_select == 3'h6 ||
         capture_mode_select == 3'h7) |-> !push;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("capture while disabled");

    property p_halt;
        @(posedge pclk) disable iff (!presetn) halted |-> !push;
    endproperty
    a_halt: assert property (p_halt) else $error("capture while halted");

    property p_bne;
        @(posedge pclk) disable iff (!presetn) push ##1 1'b1 |=> buffer_not_empty_flag;
    endproperty
    a_bne: assert property (p_bne) else $error("not-empty flag missing");

    property p_fall;
        @(posedge pclk) disable iff (!presetn)
        (capture_mode_select == 3'h2 && falling && !halted && !fifo_full) |-> push;
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge missed");

    property p_irq_every;
        @(posedge pclk) disable iff (!presetn)
        (capture_mode_select == 3'h1 && next_event && !wr_ctrl) |=> capture_irq;
    endproperty
    a_irq_every: assert property (p_irq_every) else $error("every-edge irq missing");

    property p_dma;
        @(posedge pclk) disable iff (!presetn)
        dma_request |-> $past(captures_per_interrupt) == 2'h0;
    endproperty
    a_dma: assert property (p_dma) else $error("dma with deep buffer");

    property p_pop_data;
        @(posedge pclk) disable iff (!presetn) pop |-> !fifo_empty;
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("pop from empty buffer");

    property p_bne_clear;
        @(posedge pclk) disable iff (!presetn) fifo_empty |=> !buffer_not_empty_flag;
    endproperty
    a_bne_clear: assert property (p_bne_clear) else $error("not-empty flag stuck");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (capture_mode_select == 3'h7 && rising && (cpu_sleep || cpu_idle)) |=> wake_request;
    endproperty
    a_wake: assert property (p_wake) else $error("wake request missing");

    property p_prescale;
        @(posedge pclk) disable iff (!presetn)
        (capture_mode_select == 3'h4 && rising && !halted && prescale_count == 5'h03)
            |-> next_event;
    endproperty
    a_prescale: assert property (p_prescale) else $error("fourth rising edge missed");

    c_overflow: cover property (@(posedge pclk) capture_overflow_flag);
    c_irq:      cover property (@(posedge pclk) capture_irq && captures_per_interrupt == 2'h3);
    c_wake:     cover property (@(posedge pclk) wake_request);
    c_every:    cover property (@(posedge pclk) capture_mode_select == 3'h1 && push);
    c_sixteen:  cover property (@(posedge pclk) capture_mode_select == 3'h5 && push);
endmodule

// *** rtl/capture_pkg.sv ***
// Constants for the input capture channel: register map, fields, modes.
// Assumes an APB master with 32-bit data and word-aligned registers.
// Behaviour
// - Event stores full selected timer count
// - Time base is one of two timers
// - Select bit 1 first, 0 second timer
// - Modes 101/100/011 rising edge prescaled
// - Mode 010 captures every falling edge
// - Mode 001 both edges, interrupt count ignored
// - Modes 000 and 110 disable channel
// - Mode 111 rising wake interrupt only
// - Interrupt after one to four captures
// - Four-entry first-in first-out buffer
// - Overflow flag read-only, hardware cleared
// - Not-empty flag while unread entries remain
// - Stop in idle halts channel (mode 111 interrupt and wake still fire on rising edges)
// - Pin event wakes from sleep/idle
// - DMA request only channels one, two
package capture_pkg;
    localparam logic [11:0] control_offset  = 12'h000;
    localparam logic [11:0] buffer_offset   = 12'h004;
    localparam int          stop_idle_bit   = 13;
    localparam int          time_sel_bit    = 7;
    localparam int          per_int_lsb     = 5;
    localparam int          overflow_bit    = 4;
    localparam int          not_empty_bit   = 3;
    localparam int          mode_lsb        = 0;
    localparam logic [15:0] control_reset   = 16'h0000;
    localparam logic [15:0] writable_mask   = 16'h20e7;
    localparam int          fifo_depth      = 4;
    localparam logic [4:0]  prescale_four   = 5'h04;
    localparam logic [4:0]  prescale_sixteen = 5'h10;

    typedef enum logic [2:0] {
        mode_off     = 3'h0,
        mode_every   = 3'h1,
        mode_fall    = 3'h2,
        mode_rise    = 3'h3,
        mode_rise4   = 3'h4,
        mode_rise16  = 3'h5,
        mode_unused  = 3'h6,
        mode_wake    = 3'h7
    } mode_type;
endpackage

// *** rtl/capture_fifo.sv ***
// Four-deep flop buffer of captured counts.
// Assumes the parent never pushes while full nor pops while empty.
`timescale 1ns/1ps
module capture_fifo #(
    parameter int width = 16,
    parameter int depth = capture_pkg::fifo_depth
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic [width-1:0] push_data,
    input  wire logic             pop,
    output logic      [width-1:0] head,
    output logic                  full,
    output logic                  empty
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] store [depth];
    logic [aw-1:0]    wr_ptr;
    logic [aw-1:0]    rd_ptr;
    logic [aw:0]      count;

    initial begin
        if (depth < 2 || (depth & (depth - 1)) != 0) begin
            $error("capture_fifo depth must be a power of two");
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (aw+1)'(push) - (aw+1)'(pop);
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            store[wr_ptr] <= push_data;
        end
    end

    assign head  = store[rd_ptr];
    assign full  = (count == (aw+1)'(depth));
    assign empty = (count == '0);
endmodule

// *** testbench/pin_source.sv ***
// Far-side model: drives the capture pin and two stepped time-base counts.
// Assumes the bench requests levels and steps in the pclk domain.
`timescale 1ns/1ps
module pin_source (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        level,
    input  wire logic        step,
    output logic             pin,
    output logic      [15:0] first_count,
    output logic      [15:0] second_count
);
    // Pin moves on clock edges only, as the design expects a synchronous input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pin <= 1'b0;
        else pin <= level;
    end
    // Counts move only on request, so every capture has one exact value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_count  <= 16'h1000;
            second_count <= 16'hf000;
        end else if (step) begin
            first_count  <= first_count + 16'h0101;
            second_count <= second_count - 16'h0011;
        end
    end
endmodule

// *** testbench/input_capture_channel_test.sv ***
// Self-checking bench for the capture channel, one task per scenario.
// Assumes the channel answers APB in the access phase, as handed over.
`timescale 1ns/1ps
module input_capture_channel_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, pin, irq, wake, dma, e;
    logic        cpu_idle = 0, cpu_sleep = 0, level = 0, step = 0;
    logic [15:0] cnt1, cnt2, e1 = 16'h1000, e2 = 16'hf000;
    int          fail_count = 0, checks_done = 0, cycles = 0;
    int          n_irq = 0, n_wake = 0, n_dma = 0;
    localparam logic [11:0] ctl = capture_pkg::control_offset;
    localparam logic [11:0] buf_port = capture_pkg::buffer_offset;

    input_capture_channel input_capture_channel_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_input_pin(pin),
        .first_time_base_count(cnt1), .second_time_base_count(cnt2),
        .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_irq(irq),
        .wake_request(wake), .dma_request(dma));
    pin_source pin_source_inst (
        .pclk(pclk), .presetn(presetn), .level(level), .step(step),
        .pin(pin), .first_count(cnt1), .second_count(cnt2));

    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        n_irq  += (irq === 1'b1);
        n_wake += (wake === 1'b1);
        n_dma  += (dma === 1'b1);
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is sampled high
    // Only the global cycle ceiling ends a wait that never sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge pclk) level <= 1'b1;
            repeat (3) @(posedge pclk);
            level <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask

    task automatic advance;
        @(posedge pclk) step <= 1'b1;
        @(posedge pclk) step <= 1'b0;
        e1 = e1 + 16'h0101;
        e2 = e2 - 16'h0011;
    endtask

    task automatic t_regs;
        apb(0, ctl, 0); chk(r, 32'h0);
        apb(1, ctl, 32'hffff); apb(0, ctl, 0);
        chk(r, {16'h0, capture_pkg::writable_mask});
        apb(1, ctl, 0); apb(0, 12'h008, 0); chk({31'h0, e}, 32'h1);
        $display("t_regs done");
    endtask

    task automatic t_modes;
        int exp_i[8] = '{0, 2, 1, 1, 0, 0, 0, 0};
        int b, bd;
        for (int m = 0; m < 8; m++) begin
            apb(1, ctl, 32'h80 | 32'(m));
            b = n_irq; bd = n_dma;
            pulse(1);
            apb(0, ctl, 0); chk(r[3], exp_i[m] > 0);
            chk(n_irq - b, exp_i[m]);
            chk(n_dma - bd, exp_i[m]);
            if (exp_i[m] > 0) begin
                apb(0, buf_port, 0); chk(r, {16'h0, e1});
            end
            apb(1, ctl, 0);
        end
        $display("t_modes done");
    endtask

    task automatic t_prescale;
        int b;
        for (int k = 0; k < 2; k++) begin
            apb(1, ctl, k ? 32'h85 : 32'h84);
            b = n_irq;
            pulse(k ? 16 : 8);
            chk(n_irq - b, k ? 1 : 2);
            apb(0, buf_port, 0); chk(r, {16'h0, e1});
            apb(1, ctl, 0);
        end
        $display("t_prescale done");
    endtask

    task automatic t_fifo;
        logic [15:0] q[4];
        int b;
        apb(1, ctl, 32'h63);
        b = n_irq;
        for (int i = 0; i < 5; i++) begin
            advance();
            if (i < 4) q[i] = e2;
            pulse(1);
        end
        chk(n_irq - b, 1);
        apb(0, ctl, 0); chk(r[4:3], 2'b11);
        for (int i = 0; i < 4; i++) begin
            apb(0, buf_port, 0); chk(r, {16'h0, q[i]});
        end
        apb(0, ctl, 0); chk(r[3], 1'b0);
        apb(0, buf_port, 0); chk(r, 32'h0);
        apb(1, ctl, 0); apb(0, ctl, 0); chk(r[4], 1'b0);
        $display("t_fifo done");
    endtask

    task automatic t_idle;
        int b, bi;
        apb(1, ctl, 32'h2083);
        @(posedge pclk) cpu_idle <= 1'b1;
        b = n_irq;
        pulse(1);
        chk(n_irq - b, 0);
        @(posedge pclk) cpu_idle <= 1'b0;
        pulse(1);
        chk(n_irq - b, 1);
        apb(1, ctl, 0); apb(1, ctl, 32'h7);
        @(posedge pclk) cpu_sleep <= 1'b1;
        b = n_wake; bi = n_irq;
        pulse(1);
        chk(n_wake - b, 1);
        chk(n_irq - bi, 1);
        apb(0, ctl, 0); chk(r[3], 1'b0);
        @(posedge pclk) cpu_sleep <= 1'b0;
        apb(1, ctl, 0);
        $display("t_idle done");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_prescale();
        t_fifo();
        t_idle();
        results();
    end
endmodule
